// ### pkg/hbw_pkg.sv
`default_nettype none
// shared constants and types of the host bus width adapter
package hbw_pkg;
   // data path widths
   localparam int DATA_W = 32; // full doubleword
   localparam int HALF_W = 16; // one half-word lane pair
   // host address: A[7:1] reach the pins, A[7:2] name the doubleword
   localparam int ADDR_HI = 7;
   localparam int DW_LO = 2;
   localparam int DW_W = ADDR_HI - DW_LO + 1;
   // position of the bus width indication in the hardware config word
   localparam int HWCFG_BUS32_POS = 2;
   // word swap value that selects the upper half on A1 = 0
   localparam logic [31:0] WORD_SWAP_MODE0 = 32'hFFFFFFFF;
   // reset values
   localparam logic BUS32_RESET = 1'b1; // wide bus until the strap is caught
   localparam logic [HALF_W-1:0] HOLD_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] WORD_RESET = 32'h00000000;
   localparam logic [DW_W-1:0] DW_RESET = 6'h00;
   // pairing state of one direction in narrow mode
   typedef enum logic [0:0] {
      HBW_IDLE = 1'b0, // no half-word waiting
      HBW_HALF = 1'b1  // first half seen, second expected
   } hbw_pair_t;
endpackage : hbw_pkg
`default_nettype wire

// ### pkg/hbw_lane_if.sv
`default_nettype none
// carries a doubleword and its lane steering into the lane mapper
interface hbw_lane_if;
   logic [31:0] word;     // doubleword to present
   logic hi_sel;          // upper half chosen in narrow mode
   logic bus32;           // wide bus strapped
   logic [31:0] pin_data; // value for the data pins
   modport user (output word, output hi_sel, output bus32, input pin_data);
   modport lane (input word, input hi_sel, input bus32, output pin_data);
endinterface : hbw_lane_if
`default_nettype wire

// ### hdl/hbw_lane_map.sv
`default_nettype none
// maps a doubleword onto the data byte lanes
module hbw_lane_map (
   hbw_lane_if.lane lanes
);
   // selected half-word for the narrow bus
   wire [15:0] half_word;

   // narrow mode picks one half by the swap-adjusted address bit
   assign half_word = lanes.hi_sel ? lanes.word[31:16] : lanes.word[15:0];

   // wide mode is straight through, byte 3 on the top lane;
   // narrow mode leaves the upper lanes at zero, they are never enabled
   assign lanes.pin_data = lanes.bus32 ? lanes.word : {16'h0000, half_word};
endmodule // hbw_lane_map
`default_nettype wire

// ### hdl/hbw_adapter.sv
// Contract
// - strap fixes bus width at reset
// - width shown in config bit 2
// - write halves accepted in either order
// - same-half second write discards transfer
// - read halves served in either order
// - same-half reread invalid, pairing restarts
// - narrow mode never drives upper lanes
// - wide mode maps bytes straight through
// - swap all ones: A1=0 gives bytes 3,2
// - other swap: A1=0 gives bytes 1,0
`default_nettype none
module hbw_adapter (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic STRAP_BUS32,
   input wire logic [31:0] WORD_SWAP,
   input wire logic [7:1] HOST_ADDR,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic [31:0] HOST_D_IN,
   output logic [31:0] HOST_D_OUT,
   output logic HOST_D_HI_OE_B,
   output logic HOST_D_LO_OE_B,
   output logic HOST_RVALID,
   output logic RD_INVALID,
   output logic WR_DISCARD,
   output logic [31:0] HARDWARE_CONFIG_REGISTER,
   output logic INT_RD,
   output logic [5:0] INT_RADDR,
   input wire logic [31:0] INT_RDATA,
   output logic INT_WR,
   output logic [5:0] INT_WADDR,
   output logic [31:0] INT_WDATA
);

   // ---------------------------------------------------------------
   // bus width strap
   // ---------------------------------------------------------------
   logic bus32;       // 1: wide bus, 0: narrow bus
   logic strap_taken; // strap already caught since reset

   // catch the strap on the first enabled edge after release; the
   // reset branch only loads constants so the pin never feeds the
   // asynchronous path, and nothing later can change the width
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         bus32 <= hbw_pkg::BUS32_RESET;
         strap_taken <= 1'b0;
      end else if (CE && !strap_taken) begin
         bus32 <= STRAP_BUS32;
         strap_taken <= 1'b1;
      end
   end

   // read-only width indication, all other bits read as zero
   always_comb begin
      HARDWARE_CONFIG_REGISTER = hbw_pkg::WORD_RESET;
      HARDWARE_CONFIG_REGISTER[hbw_pkg::HWCFG_BUS32_POS] = bus32;
   end

   // ---------------------------------------------------------------
   // address decode shared by both directions
   // ---------------------------------------------------------------
   wire swap_mode0; // swap register holds the mode 0 value
   wire hi_sel;     // this access names the upper half-word
   wire [5:0] dw;   // doubleword address of this access
   wire rd_go;      // read strobe seen this cycle
   wire wr_go;      // write strobe seen this cycle
   wire narrow;     // narrow bus in use

   assign swap_mode0 = (WORD_SWAP == hbw_pkg::WORD_SWAP_MODE0);
   // mode 0 inverts A1 so that A1 = 0 names the upper half
   assign hi_sel = HOST_ADDR[1] ^ swap_mode0;
   assign dw = HOST_ADDR[hbw_pkg::ADDR_HI:hbw_pkg::DW_LO];
   assign narrow = ~bus32;
   assign rd_go = CE & HOST_RD;
   // a read wins if the host strobes both, which it should never do
   assign wr_go = CE & HOST_WR & ~HOST_RD;

   // ---------------------------------------------------------------
   // read pairing
   // ---------------------------------------------------------------
   hbw_pkg::hbw_pair_t rd_state;      // read pairing state
   hbw_pkg::hbw_pair_t next_rd_state; // its next value
   logic rd_half;                     // half served by the first read
   logic [5:0] rd_dw;                 // doubleword of the open pair
   logic [31:0] rd_word;              // doubleword latched at fetch

   wire rd_hit;    // open pair and same doubleword
   wire rd_second; // other half of the open pair
   wire rd_same;   // same half again: data not valid
   wire rd_fetch;  // this read pulls a new doubleword

   // a new doubleword address is treated as a fresh pair, so a host
   // that breaks the A[2]-and-up rule gets fresh data, not stale
   assign rd_hit = (rd_state == hbw_pkg::HBW_HALF) && (dw == rd_dw);
   assign rd_second = rd_hit && (hi_sel != rd_half);
   assign rd_same = rd_hit && (hi_sel == rd_half);
   // only the first half touches the internal side, so a fifo pops
   // exactly once per doubleword
   assign rd_fetch = rd_go & (bus32 | ~rd_hit);

   assign INT_RD = rd_fetch;
   assign INT_RADDR = dw;

   // next read pairing state
   always_comb begin
      next_rd_state = rd_state;
      case (rd_state)
         hbw_pkg::HBW_IDLE: begin
            if (rd_go && narrow) begin
               next_rd_state = hbw_pkg::HBW_HALF;
            end
         end
         hbw_pkg::HBW_HALF: begin
            if (rd_go && narrow) begin
               if (rd_second || rd_same) begin
                  // pair complete, or broken: next read starts anew
                  next_rd_state = hbw_pkg::HBW_IDLE;
               end else begin
                  // different doubleword: this read opens a new pair
                  next_rd_state = hbw_pkg::HBW_HALF;
               end
            end
         end
         default: begin
            next_rd_state = hbw_pkg::HBW_IDLE;
         end
      endcase
   end

   // read pairing registers
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         rd_state <= hbw_pkg::HBW_IDLE;
         rd_half <= 1'b0;
         rd_dw <= hbw_pkg::DW_RESET;
         rd_word <= hbw_pkg::WORD_RESET;
      end else if (CE) begin
         rd_state <= next_rd_state;
         if (rd_fetch) begin
            rd_half <= hi_sel;
            rd_dw <= dw;
            rd_word <= INT_RDATA;
         end
      end
   end

   // ---------------------------------------------------------------
   // read data onto the pins
   // ---------------------------------------------------------------
   hbw_lane_if lanes ();

   // a fetch presents the fresh word, the second half the latched one
   assign lanes.word = rd_fetch ? INT_RDATA : rd_word;
   assign lanes.hi_sel = hi_sel;
   assign lanes.bus32 = bus32;

   hbw_lane_map hbw_lane_map_inst (
      .lanes(lanes)
   );

   // pins are registered; the upper lanes are enabled only on a wide
   // bus, so the narrow pins float on their pull-downs
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         HOST_D_OUT <= hbw_pkg::WORD_RESET;
         HOST_D_HI_OE_B <= 1'b1;
         HOST_D_LO_OE_B <= 1'b1;
         HOST_RVALID <= 1'b0;
         RD_INVALID <= 1'b0;
      end else if (CE) begin
         if (rd_go) begin
            HOST_D_OUT <= lanes.pin_data;
         end
         HOST_D_HI_OE_B <= ~(rd_go & bus32);
         HOST_D_LO_OE_B <= ~rd_go;
         HOST_RVALID <= rd_go;
         // flags the reread so a host can tell the data is bad
         RD_INVALID <= rd_go & narrow & rd_same;
      end
   end

   // ---------------------------------------------------------------
   // write pairing
   // ---------------------------------------------------------------
   hbw_pkg::hbw_pair_t wr_state;      // write pairing state
   hbw_pkg::hbw_pair_t next_wr_state; // its next value
   logic wr_half;                     // half written first
   logic [5:0] wr_dw;                 // doubleword of the open pair
   logic [15:0] wr_hold;              // first half-word, held back

   wire wr_hit;    // open pair and same doubleword
   wire wr_second; // other half of the open pair
   wire wr_same;   // same half again: transfer dropped
   wire wr_commit; // a full doubleword goes inward now
   wire wr_open;   // this write opens a pair
   wire [31:0] wr_merged; // held half joined with the new one

   assign wr_hit = (wr_state == hbw_pkg::HBW_HALF) && (dw == wr_dw);
   assign wr_second = wr_hit && (wr_half != hi_sel);
   assign wr_same = wr_hit && (wr_half == hi_sel);
   assign wr_commit = wr_go & (bus32 | wr_second);
   // a write to another doubleword while a half waits abandons the
   // waiting half; that is a host fault and no data is merged
   assign wr_open = wr_go & narrow & ~wr_hit;
   // the new half lands where its address says, the held one opposite
   assign wr_merged = hi_sel ? {HOST_D_IN[15:0], wr_hold}
                             : {wr_hold, HOST_D_IN[15:0]};

   // next write pairing state
   always_comb begin
      next_wr_state = wr_state;
      case (wr_state)
         hbw_pkg::HBW_IDLE: begin
            if (wr_open) begin
               next_wr_state = hbw_pkg::HBW_HALF;
            end
         end
         hbw_pkg::HBW_HALF: begin
            if (wr_go && narrow) begin
               if (wr_second || wr_same) begin
                  // committed, or discarded on a repeated half
                  next_wr_state = hbw_pkg::HBW_IDLE;
               end else begin
                  next_wr_state = hbw_pkg::HBW_HALF;
               end
            end
         end
         default: begin
            next_wr_state = hbw_pkg::HBW_IDLE;
         end
      endcase
   end

   // write pairing registers
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         wr_state <= hbw_pkg::HBW_IDLE;
         wr_half <= 1'b0;
         wr_dw <= hbw_pkg::DW_RESET;
         wr_hold <= hbw_pkg::HOLD_RESET;
      end else if (CE) begin
         wr_state <= next_wr_state;
         if (wr_open) begin
            wr_half <= hi_sel;
            wr_dw <= dw;
            wr_hold <= HOST_D_IN[15:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // write toward the internal registers and fifos
   // ---------------------------------------------------------------
   // one registered pulse per doubleword; nothing is written inward
   // for a lone or repeated half, so a fifo never sees half a word
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         INT_WR <= 1'b0;
         INT_WADDR <= hbw_pkg::DW_RESET;
         INT_WDATA <= hbw_pkg::WORD_RESET;
         WR_DISCARD <= 1'b0;
      end else if (CE) begin
         INT_WR <= wr_commit;
         if (wr_commit) begin
            INT_WADDR <= dw;
            INT_WDATA <= bus32 ? HOST_D_IN : wr_merged;
         end
         WR_DISCARD <= wr_go & narrow & wr_same;
      end
   end
endmodule // hbw_adapter
`default_nettype wire

// ### tb/hbw_adapter_monitor.sv
`default_nettype none
// watches the host and internal ports of the width adapter
module hbw_adapter_monitor (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic [7:1] HOST_ADDR,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic [31:0] HOST_D_IN,
   input wire logic [31:0] HOST_D_OUT,
   input wire logic HOST_D_HI_OE_B,
   input wire logic HOST_D_LO_OE_B,
   input wire logic HOST_RVALID,
   input wire logic RD_INVALID,
   input wire logic [31:0] HARDWARE_CONFIG_REGISTER,
   input wire logic INT_RD,
   input wire logic [5:0] INT_RADDR,
   input wire logic [31:0] INT_RDATA,
   input wire logic INT_WR,
   input wire logic [5:0] INT_WADDR,
   input wire logic [31:0] INT_WDATA
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   logic caught; // strap taken since the last reset
   logic wide; // wide bus in force
   assign wide = HARDWARE_CONFIG_REGISTER[2];
   // the first enabled edge after reset takes the strap
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B)
         caught <= 1'b0;
      else if (CE)
         caught <= 1'b1;
   end
   sequence rd_take;
      CE && HOST_RD;
   endsequence
   sequence rd_reply;
      HOST_RVALID && !HOST_D_LO_OE_B;
   endsequence
   sequence wr_take;
      CE && HOST_WR && !HOST_RD;
   endsequence
   chk_rd_answer: assert property (rd_take |=> rd_reply)
      else $error("read reply missing");
   // a low enable freezes the reply flops, so only enabled idle edges count
   chk_rd_quiet: assert property ((CE && !HOST_RD) |=> !HOST_RVALID && HOST_D_LO_OE_B)
      else $error("reply without read");
   chk_hi_float: assert property (!wide |-> HOST_D_HI_OE_B && HOST_D_OUT[31:16] == 16'h0000)
      else $error("upper lanes driven in narrow mode");
   chk_cfg_bits: assert property (HARDWARE_CONFIG_REGISTER[31:3] == 29'h0 && HARDWARE_CONFIG_REGISTER[1:0] == 2'h0)
      else $error("config word has stray bits");
   chk_width_fixed: assert property (caught |=> $stable(HARDWARE_CONFIG_REGISTER))
      else $error("bus width changed after strap");
   chk_wide_lanes: assert property (wide ##0 rd_take |=> HOST_D_OUT == $past(INT_RDATA) && !HOST_D_HI_OE_B)
      else $error("wide read lanes wrong");
   chk_wide_commit: assert property (wide ##0 wr_take |=> INT_WR && INT_WDATA == $past(HOST_D_IN)
      && INT_WADDR == $past(HOST_ADDR[7:2]))
      else $error("wide write not committed");
   chk_no_commit: assert property ((CE && !(HOST_WR && !HOST_RD)) |=> !INT_WR)
      else $error("commit without write");
   chk_ce_freeze: assert property (!CE |=> $stable(HOST_D_OUT) && $stable(HOST_RVALID)
      && $stable(INT_WR) && $stable(INT_WDATA))
      else $error("state moved while enable low");
   chk_fetch_addr: assert property (INT_RD |-> CE && HOST_RD && INT_RADDR == HOST_ADDR[7:2])
      else $error("internal read misplaced");
   chk_invalid_reply: assert property (RD_INVALID |-> HOST_RVALID && !wide)
      else $error("invalid flag out of place");
endmodule // hbw_adapter_monitor
bind hbw_adapter hbw_adapter_monitor hbw_adapter_monitor_inst (.CLOCK(CLOCK), .RST_B(RST_B),
   .CE(CE), .HOST_ADDR(HOST_ADDR), .HOST_RD(HOST_RD), .HOST_WR(HOST_WR), .HOST_D_IN(HOST_D_IN),
   .HOST_D_OUT(HOST_D_OUT), .HOST_D_HI_OE_B(HOST_D_HI_OE_B), .HOST_D_LO_OE_B(HOST_D_LO_OE_B),
   .HOST_RVALID(HOST_RVALID), .RD_INVALID(RD_INVALID), .INT_RD(INT_RD), .INT_RADDR(INT_RADDR),
   .HARDWARE_CONFIG_REGISTER(HARDWARE_CONFIG_REGISTER), .INT_RDATA(INT_RDATA), .INT_WR(INT_WR),
   .INT_WADDR(INT_WADDR), .INT_WDATA(INT_WDATA));
`default_nettype wire

// ### tb/hbw_host_model.sv
`default_nettype none
// host processor on the narrow or wide data bus
module hbw_host_model (
   input wire logic clock,
   input wire logic narrow,
   output logic [7:1] addr,
   output logic rd,
   output logic wr,
   output logic [31:0] d
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus idle at time zero
   initial begin
      addr = 7'h00;
      rd = 1'b0;
      wr = 1'b0;
      d = 32'h00000000;
   end
   // one access per call; strobes stay up across back-to-back calls
   // a is the byte address; only A[7:1] reach the pins
   task automatic access(input logic r, input logic w, input logic [7:0] a, input logic [31:0] v);
      addr <= a[7:1];
      rd <= r;
      wr <= w;
      d <= narrow ? {16'h0000, v[15:0]} : v; // pull-downs hold the unused lanes low
      @(posedge clock);
   endtask
   // released bus: data lines wander so a stale value never passes
   task automatic idle();
      rd <= 1'b0;
      wr <= 1'b0;
      d <= ~d;
      @(posedge clock);
   endtask
endmodule // hbw_host_model
`default_nettype wire

// ### tb/hbw_adapter_tb.sv
`default_nettype none
module hbw_adapter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst_b, strap, ce, rd, wr, rvalid, rd_inv, wr_disc, int_rd, int_wr;
   logic [31:0] swap, d_in, d_out, cfg, int_rdata, int_wdata;
   logic [7:1] addr;
   logic [5:0] int_raddr, int_waddr;
   int miscompares = 0;
   int checked = 0;
   int fetches = 0; // internal reads seen
   int drops = 0; // discard pulses seen
   logic [31:0] rq[$]; // read replies
   logic iq[$]; // invalid flags beside them
   logic [37:0] wq[$]; // commits, address over data
   // internal store: each half of each doubleword distinct
   function automatic logic [31:0] rdata_of(input logic [5:0] a);
      return {a, 2'h1, 8'hC3, a, 2'h2, 8'h96};
   endfunction
   assign int_rdata = rdata_of(int_raddr);
   hbw_adapter hbw_adapter_inst (.CLOCK(clock), .RST_B(rst_b), .CE(ce), .STRAP_BUS32(strap),
      .WORD_SWAP(swap), .HOST_ADDR(addr), .HOST_RD(rd), .HOST_WR(wr), .HOST_D_IN(d_in),
      .HOST_D_OUT(d_out), .HOST_D_HI_OE_B(), .HOST_D_LO_OE_B(), .HOST_RVALID(rvalid),
      .RD_INVALID(rd_inv), .WR_DISCARD(wr_disc), .HARDWARE_CONFIG_REGISTER(cfg), .INT_RD(int_rd),
      .INT_RADDR(int_raddr), .INT_RDATA(int_rdata), .INT_WR(int_wr), .INT_WADDR(int_waddr),
      .INT_WDATA(int_wdata));
   hbw_host_model host (.clock(clock), .narrow(!strap), .addr(addr), .rd(rd), .wr(wr), .d(d_in));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // log replies and commits mid-cycle, where they have settled
   always @(negedge clock) begin
      if (rvalid === 1'b1) begin
         rq.push_back(d_out);
         iq.push_back(rd_inv);
      end
      if (int_wr === 1'b1)
         wq.push_back({int_waddr, int_wdata});
      if (int_rd === 1'b1)
         fetches++;
      if (wr_disc === 1'b1)
         drops++;
   end
   task automatic chk(input string what, input logic [37:0] exp, input logic [37:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset(input logic s);
      rst_b <= 1'b0;
      strap <= s;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      repeat (2) @(posedge clock);
      rq.delete();
      wq.delete();
      iq.delete();
      fetches = 0;
      drops = 0;
   endtask
   // width shows in the config word and ignores later strap moves
   task automatic t_width(input logic s);
      chk("cfg", {29'h0, s, 2'h0}, cfg);
      strap <= ~s;
      repeat (3) @(posedge clock);
      chk("cfg held", {29'h0, s, 2'h0}, cfg);
      strap <= s;
      @(posedge clock);
   endtask
   // wide read then write, straight byte lanes
   task automatic t_wide();
      host.access(1'b1, 1'b0, 8'h10, 32'h0);
      host.access(1'b0, 1'b1, 8'h24, 32'h89ABCDEF);
      repeat (2) host.idle();
      chk("wide replies", 1, rq.size());
      chk("wide rdata", rdata_of(6'h04), rq.pop_front());
      chk("wide commits", 1, wq.size());
      chk("wide commit", {6'h09, 32'h89ABCDEF}, wq.pop_front());
   endtask
   // narrow pairs both orders, one same-half repeat
   task automatic t_nwrite();
      host.access(1'b0, 1'b1, 8'h22, 32'hBBBB);
      host.access(1'b0, 1'b1, 8'h22, 32'hCCCC);
      host.access(1'b0, 1'b1, 8'h22, 32'h1111);
      host.access(1'b0, 1'b1, 8'h20, 32'h2222);
      host.access(1'b0, 1'b1, 8'h30, 32'h3333);
      host.access(1'b0, 1'b1, 8'h32, 32'h4444);
      repeat (2) host.idle();
      chk("discards", 1, drops);
      chk("commits", 2, wq.size());
      chk("hi first", {6'h08, 32'h11112222}, wq.pop_front());
      chk("lo first", {6'h0C, 32'h44443333}, wq.pop_front());
   endtask
   // strobes under a low enable leave no reply, fetch or held half
   task automatic t_freeze();
      ce <= 1'b0;
      host.access(1'b0, 1'b1, 8'h50, 32'h5555);
      host.access(1'b1, 1'b0, 8'h54, 32'h0);
      ce <= 1'b1;
      host.idle();
      chk("frozen fetches", 0, fetches);
      chk("frozen replies", 0, rq.size());
      // a half opened while frozen would merge 5555 here instead
      host.access(1'b0, 1'b1, 8'h52, 32'h6666);
      host.access(1'b0, 1'b1, 8'h50, 32'h7777);
      repeat (2) host.idle();
      chk("frozen commits", 1, wq.size());
      chk("after freeze", {6'h14, 32'h66667777}, wq.pop_front());
   endtask
   // narrow pair then same-half repeat and fresh fetch
   task automatic t_nread(input logic [31:0] sw);
      logic [31:0] r;
      logic [15:0] a0;
      logic [15:0] a1;
      r = rdata_of(6'h10);
      a0 = (sw == 32'hFFFFFFFF) ? r[31:16] : r[15:0];
      a1 = (sw == 32'hFFFFFFFF) ? r[15:0] : r[31:16];
      swap <= sw;
      host.idle();
      host.access(1'b1, 1'b0, 8'h40, 32'h0);
      host.access(1'b1, 1'b0, 8'h42, 32'h0);
      host.access(1'b1, 1'b0, 8'h40, 32'h0);
      host.access(1'b1, 1'b0, 8'h40, 32'h0);
      host.access(1'b1, 1'b0, 8'h42, 32'h0);
      // completes the fresh pair so the next call starts closed
      host.access(1'b1, 1'b0, 8'h40, 32'h0);
      repeat (2) host.idle();
      chk("fetches", 3, fetches);
      chk("replies", 6, rq.size());
      chk("pair a1=0", {16'h0, a0}, rq[0]);
      chk("pair a1=1", {16'h0, a1}, rq[1]);
      chk("flags", 6'b000100, {iq[0], iq[1], iq[2], iq[3], iq[4], iq[5]});
      chk("fresh", {16'h0, a1}, rq[4]);
      chk("pair closed", {16'h0, a0}, rq[5]);
      rq.delete();
      iq.delete();
      fetches = 0;
   endtask
   task automatic close_out();
      if (miscompares == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      rst_b = 1'b0;
      strap = 1'b1;
      ce = 1'b1;
      swap = 32'h0;
      do_reset(1'b1);
      t_width(1'b1);
      t_wide();
      do_reset(1'b0);
      t_width(1'b0);
      t_nwrite();
      t_freeze();
      t_nread(32'h00000000);
      t_nread(32'hFFFFFFFF);
      close_out();
   end
   // cuts a hang short well past the expected run
   initial begin
      #(100 * 2000);
      miscompares++;
      close_out();
   end
endmodule // hbw_adapter_tb
`default_nettype wire
